// ===== verilog/memmap_pkg.sv
package memmap_pkg;

    localparam logic [15:0] VEC_LO = 16'h0000;
    localparam logic [15:0] VEC_HI = 16'h003F;
    localparam logic [15:0] VEC_WDT = 16'h0004;
    localparam logic [15:0] VEC_LAST_IRQ = 16'h001C;
    localparam logic [15:0] VEC_BREAK = 16'h003E;
    localparam logic [15:0] TCALL_LO = 16'h0040;
    localparam logic [15:0] TCALL_HI = 16'h007F;
    localparam logic [15:0] FCALL_LO = 16'h0800;
    localparam logic [15:0] FCALL_HI = 16'h0FFF;
    localparam logic [16:0] ROM_SIZE_V0 = 17'h04000;
    localparam logic [16:0] ROM_SIZE_V1 = 17'h06000;
    localparam logic [16:0] ROM_SIZE_V2 = 17'h08000;
    localparam logic [16:0] ROM_SIZE_V3 = 17'h0A000;
    localparam logic [16:0] ROM_SIZE_V4 = 17'h0F000;
    localparam logic [15:0] XRAM_LO = 16'hF400;
    localparam logic [15:0] XRAM_HI = 16'hF7FF;
    localparam logic [15:0] DISP_LO = 16'hFA50;
    localparam logic [15:0] DISP_HI = 16'hFA7F;
    localparam logic [15:0] SBUF_LO = 16'hFAC0;
    localparam logic [15:0] SBUF_HI = 16'hFAFF;
    localparam logic [15:0] HSRAM_LO_SMALL = 16'hFD00;
    localparam logic [15:0] HSRAM_LO_LARGE = 16'hFB00;
    localparam logic [15:0] HSRAM_HI = 16'hFEFF;
    localparam logic [15:0] GREG_LO = 16'hFEE0;
    localparam logic [15:0] GREG_HI = 16'hFEFF;
    localparam logic [15:0] SFR_LO = 16'hFF00;
    localparam logic [15:0] SFR_HI = 16'hFFFF;
    localparam logic [15:0] PC_RESET = 16'h0000;

    typedef enum logic [2:0] {
        VAR_ROM16K,
        VAR_ROM24K,
        VAR_ROM32K,
        VAR_ROM40K,
        VAR_PROM60K
    } variant_t;

    // One-hot region selects; at most one bit is ever set.
    typedef struct packed {
        logic rom;
        logic xram;
        logic disp;
        logic sbuf;
        logic hsram;
        logic sfr;
    } region_t;

    // Sub-area flags inside the selected region.
    typedef struct packed {
        logic vector;
        logic vec_odd;
        logic tcall;
        logic fcall;
        logic greg;
        logic data_win;
    } area_t;

    typedef enum logic [1:0] {
        ACC_FETCH,
        ACC_READ,
        ACC_WRITE,
        ACC_STACK
    } access_t;

endpackage

// ===== verilog/memory_map_decoder.sv
`timescale 1ns/1ns
// Contract
// - Decode flat 64 KB, 16-bit shared address.
// - 0000H-003FH is the vector table.
// - Vector low byte even, high byte odd.
// - Fixed vector slots reset through break.
// - 0040H-007FH is the table-call area.
// - 0800H-0FFFH is the fixed-call entry area.
// - ROM from zero, size set by variant.
// - High-speed RAM 512 or 1024 bytes.
// - FEE0H-FEFFH holds four register banks.
// - Only PROM variant decodes F400H-F7FFH.
// - FAC0H-FAFFH is serial buffer RAM.
// - Buffer RAM is plain RAM without auto mode.
// - FA50H-FA7FH is display RAM, also plain.
// - FF00H-FFFFH is the SFR area.
// - Data window FD00H or FB00H up to FFFFH.
// - High-speed RAM accepts stack pushes and pops.
// - Fetches use the program counter address.
// - Active-low reset clears decoder state.
// - Reset loads program counter from vector 0000H.
module memory_map_decoder (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Product variant, static strap
    input wire memmap_pkg::variant_t variant,
    // Core access request
    input wire logic req,
    input wire memmap_pkg::access_t acc,
    input wire logic [15:0] data_addr,
    input wire logic [15:0] program_counter,
    input wire logic auto_serial_on,
    // Reset vector bytes read back from ROM
    input wire logic [7:0] rom_data,
    // Decoded result, one cycle after the request
    output memmap_pkg::region_t region_r,
    output memmap_pkg::area_t area_r,
    output logic [15:0] addr_r,
    output logic valid_r,
    output logic sbuf_serial_r,
    output logic stack_ok_r,
    output logic [1:0] greg_bank_r,
    output logic [2:0] greg_index_r,
    // Reset vector fetch
    output logic [15:0] reset_pc_r,
    output logic boot_done_r
);

    typedef enum logic [1:0] {
        BOOT_LO,
        BOOT_HI,
        BOOT_RUN
    } boot_t;

    boot_t boot_r;
    logic [15:0] addr;
    logic [16:0] rom_size;
    logic [15:0] hsram_lo;
    memmap_pkg::region_t region_nxt;
    memmap_pkg::area_t area_nxt;
    logic vec_slot_nxt;
    logic vec_slot_r;

    // Fetches address from the program counter, data from the core.
    always_comb begin
        if (acc == memmap_pkg::ACC_FETCH) begin
            addr = program_counter;
        end else begin
            addr = data_addr;
        end
    end

    always_comb begin
        unique case (variant)
            memmap_pkg::VAR_ROM16K: rom_size = memmap_pkg::ROM_SIZE_V0;
            memmap_pkg::VAR_ROM24K: rom_size = memmap_pkg::ROM_SIZE_V1;
            memmap_pkg::VAR_ROM32K: rom_size = memmap_pkg::ROM_SIZE_V2;
            memmap_pkg::VAR_ROM40K: rom_size = memmap_pkg::ROM_SIZE_V3;
            memmap_pkg::VAR_PROM60K: rom_size = memmap_pkg::ROM_SIZE_V4;
            default: rom_size = memmap_pkg::ROM_SIZE_V0;
        endcase
    end

    // Two smallest parts carry 512 bytes, the rest 1024.
    always_comb begin
        if (variant == memmap_pkg::VAR_ROM16K ||
                variant == memmap_pkg::VAR_ROM24K) begin
            hsram_lo = memmap_pkg::HSRAM_LO_SMALL;
        end else begin
            hsram_lo = memmap_pkg::HSRAM_LO_LARGE;
        end
    end

    // Ranges are disjoint for every variant, so the select is one-hot.
    always_comb begin
        region_nxt = '0;
        area_nxt = '0;
        if ({1'b0, addr} < rom_size) begin
            region_nxt.rom = 1'b1;
        end else if (variant == memmap_pkg::VAR_PROM60K &&
                addr >= memmap_pkg::XRAM_LO &&
                addr <= memmap_pkg::XRAM_HI) begin
            region_nxt.xram = 1'b1;
        end else if (addr >= memmap_pkg::DISP_LO &&
                addr <= memmap_pkg::DISP_HI) begin
            region_nxt.disp = 1'b1;
        end else if (addr >= memmap_pkg::SBUF_LO &&
                addr <= memmap_pkg::SBUF_HI) begin
            region_nxt.sbuf = 1'b1;
        end else if (addr >= hsram_lo && addr <= memmap_pkg::HSRAM_HI) begin
            region_nxt.hsram = 1'b1;
        end else if (addr >= memmap_pkg::SFR_LO) begin
            region_nxt.sfr = 1'b1;
        end
        area_nxt.vector = addr <= memmap_pkg::VEC_HI;
        area_nxt.vec_odd = area_nxt.vector && addr[0];
        area_nxt.tcall = addr >= memmap_pkg::TCALL_LO &&
                addr <= memmap_pkg::TCALL_HI;
        area_nxt.fcall = addr >= memmap_pkg::FCALL_LO &&
                addr <= memmap_pkg::FCALL_HI;
        area_nxt.greg = addr >= memmap_pkg::GREG_LO &&
                addr <= memmap_pkg::GREG_HI;
        area_nxt.data_win = addr >= hsram_lo;
    end

    // A slot is the low byte of a fixed entry: reset, then the interrupt
    // entries from the watchdog up, then the break entry. The bytes in
    // between are reserved, so they never count as a slot.
    always_comb begin
        vec_slot_nxt = 1'h0;
        if (addr == memmap_pkg::VEC_LO) begin
            vec_slot_nxt = 1'h1;
        end else if (addr >= memmap_pkg::VEC_WDT &&
                addr <= memmap_pkg::VEC_LAST_IRQ && !addr[0]) begin
            vec_slot_nxt = 1'h1;
        end else if (addr == memmap_pkg::VEC_BREAK) begin
            vec_slot_nxt = 1'h1;
        end
    end

    // The slot flag is answered together with the region selects.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            vec_slot_r <= 1'h0;
        end else begin
            vec_slot_r <= req && vec_slot_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            region_r <= '0;
            area_r <= '0;
            addr_r <= 16'h0000;
            valid_r <= 1'b0;
            sbuf_serial_r <= 1'b0;
            stack_ok_r <= 1'b0;
            greg_bank_r <= 2'h0;
            greg_index_r <= 3'h0;
        end else begin
            region_r <= req ? region_nxt : '0;
            area_r <= req ? area_nxt : '0;
            addr_r <= addr;
            valid_r <= req;
            // Without auto mode the buffer is ordinary RAM.
            sbuf_serial_r <= req && region_nxt.sbuf && auto_serial_on;
            stack_ok_r <= req && acc == memmap_pkg::ACC_STACK &&
                    region_nxt.hsram;
            greg_bank_r <= addr[4:3];
            greg_index_r <= addr[2:0];
        end
    end

    // Boot reads the reset vector: low byte at 0000H, high at 0001H.
    // The ROM answers rom_data in the cycle the address is presented.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            boot_r <= BOOT_LO;
            reset_pc_r <= memmap_pkg::PC_RESET;
            boot_done_r <= 1'b0;
        end else begin
            unique case (boot_r)
                BOOT_LO: begin
                    reset_pc_r[7:0] <= rom_data;
                    boot_r <= BOOT_HI;
                end
                BOOT_HI: begin
                    reset_pc_r[15:8] <= rom_data;
                    boot_r <= BOOT_RUN;
                    boot_done_r <= 1'b1;
                end
                BOOT_RUN: begin
                    boot_r <= BOOT_RUN;
                end
            endcase
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // Boot takes exactly two cycles after reset is released.
    sequence boot_seq;
        !boot_done_r ##1 !boot_done_r ##1 boot_done_r;
    endsequence

    // Once loaded, the start address must not drift while the core runs.
    sequence boot_held_s;
        boot_done_r && $stable(reset_pc_r);
    endsequence

    // A data access takes its address from the core, not the counter.
    sequence data_req_s;
        req && acc != memmap_pkg::ACC_FETCH;
    endsequence

    // This matches a stack access that falls outside high-speed RAM.
    sequence stack_miss_s;
        req && acc == memmap_pkg::ACC_STACK &&
                (addr < hsram_lo || addr > memmap_pkg::HSRAM_HI);
    endsequence

    // This matches a buffer access while the automatic mode is off.
    sequence sbuf_plain_s;
        req && !auto_serial_on && addr >= memmap_pkg::SBUF_LO &&
                addr <= memmap_pkg::SBUF_HI;
    endsequence

    // Selects are one-hot and follow the request by exactly one cycle.
    onehot_select_a: assert property ($onehot0(region_r))
        else $error("more than one region selected");
    valid_follow_a: assert property (req |=> valid_r)
        else $error("request not answered in the next cycle");
    idle_clear_a: assert property (!req |=> !valid_r
            && region_r == '0 && area_r == '0 && !vec_slot_r)
        else $error("selects raised without a request");
    outside_none_a: assert property (req
            && variant != memmap_pkg::VAR_PROM60K
            && addr >= memmap_pkg::XRAM_LO && addr <= memmap_pkg::XRAM_HI
            |=> region_r == '0)
        else $error("unmapped address selected a region");

    // The chosen address is the counter for fetches, the core otherwise.
    fetch_pc_a: assert property (req && acc == memmap_pkg::ACC_FETCH
            |=> addr_r == $past(program_counter))
        else $error("fetch did not use program counter");
    data_source_a: assert property (data_req_s
            |=> addr_r == $past(data_addr))
        else $error("data access did not use the data address");

    // Program memory areas all sit inside the ROM of the smallest part.
    rom_bound_a: assert property (req && {1'b0, addr} < rom_size
            |=> region_r.rom)
        else $error("rom address not selected as rom");
    vector_rom_a: assert property (req && addr <= memmap_pkg::VEC_HI
            |=> region_r.rom && area_r.vector)
        else $error("vector table not inside program memory");
    vector_odd_a: assert property (area_r.vec_odd
            |-> area_r.vector && addr_r[0])
        else $error("vector odd byte flag wrong");
    tcall_rom_a: assert property (area_r.tcall
            |-> region_r.rom && addr_r >= memmap_pkg::TCALL_LO
            && addr_r <= memmap_pkg::TCALL_HI)
        else $error("table call area misplaced");
    fcall_rom_a: assert property (area_r.fcall
            |-> region_r.rom && addr_r >= memmap_pkg::FCALL_LO
            && addr_r <= memmap_pkg::FCALL_HI)
        else $error("fixed call area misplaced");

    // Only the fixed entries count as slots; the reserved gap never does.
    vector_slot_a: assert property (vec_slot_r
            |-> area_r.vector && !area_r.vec_odd)
        else $error("vector slot outside even table bytes");
    wdt_slot_a: assert property (req && addr == memmap_pkg::VEC_WDT
            |=> vec_slot_r)
        else $error("watchdog entry not decoded as a slot");
    break_slot_a: assert property (req
            && addr == memmap_pkg::VEC_BREAK |=> vec_slot_r)
        else $error("break entry not decoded as a slot");
    reserved_gap_a: assert property (req
            && addr > memmap_pkg::VEC_LAST_IRQ
            && addr < memmap_pkg::VEC_BREAK |=> !vec_slot_r)
        else $error("reserved vector bytes decoded as a slot");

    // Data regions decode on their own ranges and nowhere else.
    xram_only_prom_a: assert property (region_r.xram
            |-> variant == memmap_pkg::VAR_PROM60K)
        else $error("expansion ram on wrong variant");
    xram_range_a: assert property (req
            && variant == memmap_pkg::VAR_PROM60K
            && addr >= memmap_pkg::XRAM_LO && addr <= memmap_pkg::XRAM_HI
            |=> region_r.xram)
        else $error("expansion ram not decoded");
    disp_range_a: assert property (req && addr >= memmap_pkg::DISP_LO
            && addr <= memmap_pkg::DISP_HI |=> region_r.disp)
        else $error("display ram not decoded");
    sbuf_range_a: assert property (req && addr >= memmap_pkg::SBUF_LO
            && addr <= memmap_pkg::SBUF_HI |=> region_r.sbuf)
        else $error("buffer ram not decoded");
    sbuf_mode_a: assert property (sbuf_serial_r |-> region_r.sbuf)
        else $error("serial flag outside buffer ram");
    sbuf_plain_a: assert property (sbuf_plain_s
            |=> region_r.sbuf && !sbuf_serial_r)
        else $error("buffer ram not plain without auto mode");
    hsram_base_a: assert property (region_r.hsram
            |-> addr_r >= hsram_lo && addr_r <= memmap_pkg::HSRAM_HI)
        else $error("high speed ram outside its size");
    small_hsram_a: assert property (req
            && (variant == memmap_pkg::VAR_ROM16K
            || variant == memmap_pkg::VAR_ROM24K)
            && addr < memmap_pkg::HSRAM_LO_SMALL |=> !region_r.hsram)
        else $error("small part decoded high speed ram too low");
    greg_bank_a: assert property (area_r.greg |-> region_r.hsram
            && addr_r[15:5] == memmap_pkg::GREG_LO[15:5])
        else $error("register bank area misplaced");
    greg_split_a: assert property (area_r.greg
            |-> {greg_bank_r, greg_index_r} == addr_r[4:0])
        else $error("register bank fields do not match address");
    window_a: assert property (area_r.data_win
            |-> addr_r >= hsram_lo)
        else $error("data window below its base");
    window_top_a: assert property (req
            && addr >= memmap_pkg::HSRAM_LO_SMALL |=> area_r.data_win)
        else $error("data window missing at its top");
    sfr_area_a: assert property (req && addr >= memmap_pkg::SFR_LO
            |=> region_r.sfr && addr_r >= memmap_pkg::SFR_LO)
        else $error("sfr area not decoded");

    // The stack may live only in high-speed RAM.
    stack_hsram_a: assert property (req
            && acc == memmap_pkg::ACC_STACK && addr >= hsram_lo
            && addr <= memmap_pkg::HSRAM_HI |=> stack_ok_r)
        else $error("stack access refused in high speed ram");
    stack_miss_a: assert property (stack_miss_s |=> !stack_ok_r)
        else $error("stack access outside high speed ram");

    // The reset vector is loaded once and then left alone.
    boot_vec_a: assert property ($rose(rstn) |-> boot_seq)
        else $error("reset vector load out of step");
    boot_hold_a: assert property (boot_done_r |=> boot_held_s)
        else $error("start address changed after boot");

endmodule // memory_map_decoder

// ===== sim/core_model.sv
`timescale 1ns/1ns
module core_model #(
    parameter logic [15:0] BOOT_VEC = 16'h0A5C
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Program memory byte seen at boot
    output logic [7:0] rom_data
);
    logic [7:0] step_r;

    always_ff @(posedge clk) begin
        if (!rstn) step_r <= 8'h00;
        else step_r <= step_r + 8'h01;
    end

    // After the two boot bytes the bus keeps changing, so a late capture
    // cannot match the vector by luck.
    always_comb begin
        case (step_r)
            8'h00: rom_data = BOOT_VEC[7:0];
            8'h01: rom_data = BOOT_VEC[15:8];
            default: rom_data = ~step_r;
        endcase
    end
endmodule // core_model

// ===== sim/testbench.sv
`timescale 1ns/1ns
module testbench;
    localparam logic [15:0] BOOT_VEC = 16'h0A5C;
    localparam logic [16:0] ROM_SZ [5] = '{17'h04000, 17'h06000,
        17'h08000, 17'h0A000, 17'h0F000};
    // Only assigned register addresses are touched in the top area.
    localparam logic [15:0] ADDRS [39] = '{16'h0000, 16'h0001, 16'h0004,
        16'h001C, 16'h0020, 16'h003E, 16'h003F, 16'h0040, 16'h007F, 16'h0080,
        16'h0800, 16'h0FFF, 16'h3FFF, 16'h4000, 16'h5FFF, 16'h6000,
        16'h7FFF, 16'h8000, 16'h9FFF, 16'hA000, 16'hEFFF, 16'hF000,
        16'hF3FF, 16'hF400, 16'hF7FF, 16'hF800, 16'hFA4F, 16'hFA50,
        16'hFA7F, 16'hFA80, 16'hFAC0, 16'hFAFF, 16'hFB00, 16'hFCFF,
        16'hFD00, 16'hFEE8, 16'hFEFF, 16'hFF00, 16'hFF2C};
    logic clk, rstn, req, auto_serial_on;
    memmap_pkg::variant_t variant;
    memmap_pkg::access_t acc;
    logic [15:0] data_addr, program_counter, addr_r, reset_pc_r;
    logic [7:0] rom_data;
    memmap_pkg::region_t region_r;
    memmap_pkg::area_t area_r;
    logic valid_r, sbuf_serial_r, stack_ok_r, boot_done_r;
    logic [1:0] greg_bank_r;
    logic [2:0] greg_index_r;
    int errors, total_checks;

    memory_map_decoder i_memory_map_decoder (.clk, .rstn, .variant, .req,
        .acc, .data_addr, .program_counter, .auto_serial_on, .rom_data,
        .region_r, .area_r, .addr_r, .valid_r, .sbuf_serial_r, .stack_ok_r,
        .greg_bank_r, .greg_index_r, .reset_pc_r, .boot_done_r);
    core_model #(.BOOT_VEC(BOOT_VEC)) i_core_model (.clk, .rstn, .rom_data);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string name, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d checks %0d", errors, total_checks);
        if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Fetches put the address on the program counter and its inverse on the
    // data address, so the wrong source shows up in addr_r.
    task automatic op(input memmap_pkg::access_t k, input logic [15:0] a,
            input logic s);
        @(posedge clk);
        req <= 1'b1;
        acc <= k;
        auto_serial_on <= s;
        data_addr <= (k == memmap_pkg::ACC_FETCH) ? ~a : a;
        program_counter <= (k == memmap_pkg::ACC_FETCH) ? a : ~a;
        @(posedge clk);
        #1;
    endtask

    task automatic t_boot(input int v);
        @(posedge clk);
        variant <= memmap_pkg::variant_t'(v);
        rstn <= 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk("rst_region", {10'h000, region_r}, 16'h0000);
        chk("rst_valid", {15'h0000, valid_r}, 16'h0000);
        chk("rst_done", {15'h0000, boot_done_r}, 16'h0000);
        repeat (2) @(posedge clk);
        #1;
        chk("boot_pc", reset_pc_r, BOOT_VEC);
        chk("boot_done", {15'h0000, boot_done_r}, 16'h0001);
    endtask

    task automatic t_decode();
        memmap_pkg::region_t er;
        memmap_pkg::area_t ea;
        logic [15:0] a, hs;
        for (int v = 0; v < 5; v++) begin
            t_boot(v);
            hs = (v > 1) ? 16'hFB00 : 16'hFD00;
            for (int i = 0; i < 39; i++) begin
                a = ADDRS[i];
                op(i[0] ? memmap_pkg::ACC_FETCH : memmap_pkg::ACC_READ, a,
                    1'b0);
                er.rom = {1'b0, a} < ROM_SZ[v];
                er.xram = v == 4 && a inside {[16'hF400:16'hF7FF]};
                er.disp = a inside {[16'hFA50:16'hFA7F]};
                er.sbuf = a inside {[16'hFAC0:16'hFAFF]};
                er.hsram = a >= hs && a <= 16'hFEFF;
                er.sfr = a >= 16'hFF00;
                ea.vector = a <= 16'h003F;
                ea.vec_odd = ea.vector && a[0];
                ea.tcall = a inside {[16'h0040:16'h007F]};
                ea.fcall = a inside {[16'h0800:16'h0FFF]};
                ea.greg = a inside {[16'hFEE0:16'hFEFF]};
                ea.data_win = a >= hs;
                chk("region", {10'h000, region_r}, {10'h000, er});
                chk("area", {10'h000, area_r}, {10'h000, ea});
                chk("addr", addr_r, a);
                chk("valid", {15'h0000, valid_r}, 16'h0001);
                if (ea.greg) begin
                    chk("bank", {14'h0000, greg_bank_r}, {14'h0000, a[4:3]});
                    chk("index", {13'h0000, greg_index_r}, {13'h0000, a[2:0]});
                end
            end
        end
    endtask

    task automatic t_idle();
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
        #1;
        chk("idle_valid", {15'h0000, valid_r}, 16'h0000);
        chk("idle_region", {10'h000, region_r}, 16'h0000);
        chk("idle_area", {10'h000, area_r}, 16'h0000);
    endtask

    task automatic t_modes();
        op(memmap_pkg::ACC_WRITE, 16'hFAC0, 1'b1);
        chk("sbuf_auto", {15'h0000, sbuf_serial_r}, 16'h0001);
        op(memmap_pkg::ACC_WRITE, 16'hFA50, 1'b1);
        chk("disp_auto", {15'h0000, sbuf_serial_r}, 16'h0000);
        op(memmap_pkg::ACC_READ, 16'hFAFF, 1'b0);
        chk("sbuf_plain", {15'h0000, sbuf_serial_r}, 16'h0000);
        chk("sbuf_region", {10'h000, region_r}, 16'h0004);
        op(memmap_pkg::ACC_STACK, 16'hFB00, 1'b0);
        chk("stack_low", {15'h0000, stack_ok_r}, 16'h0001);
        op(memmap_pkg::ACC_STACK, 16'hFEFF, 1'b0);
        chk("stack_top", {15'h0000, stack_ok_r}, 16'h0001);
        op(memmap_pkg::ACC_STACK, 16'hFA60, 1'b0);
        chk("stack_out", {15'h0000, stack_ok_r}, 16'h0000);
    endtask

    initial begin
        #(20000 * 100);
        errors++;
        stop_test();
    end

    initial begin
        rstn = 1'b0;
        req = 1'b0;
        acc = memmap_pkg::ACC_READ;
        data_addr = 16'h0000;
        program_counter = 16'h0000;
        auto_serial_on = 1'b0;
        variant = memmap_pkg::VAR_ROM16K;
        errors = 0;
        total_checks = 0;
        t_decode();
        t_idle();
        t_modes();
        // Reset again in mid-run with a request still held high.
        t_boot(4);
        stop_test();
    end
endmodule // testbench
